// ===== common/acif_map.svh
/*
 Register offsets, field positions, reset values and settle times of the AC input filter block.
 Assumes a 100 MHz system clock and 32-bit APB word addressing.
*/
`ifndef ACIF_MAP_SVH
`define ACIF_MAP_SVH
// Register byte offsets
`define ACIF_OFF_CTRL 12'h000
`define ACIF_OFF_STAT 12'h004
`define ACIF_OFF_LEVEL 12'h008
`define ACIF_OFF_QUAL 12'h00C
`define ACIF_OFF_RISE 12'h010
`define ACIF_OFF_FALL 12'h018
`define ACIF_OFF_IRQ_STS 12'h020
`define ACIF_OFF_IRQ_MSK 12'h024
// Control fields
`define ACIF_CTRL_RUN 0
`define ACIF_CTRL_LINK 1
`define ACIF_CTRL_PROG 2
// Status fields
`define ACIF_STAT_RUN 0
`define ACIF_STAT_LOST 1
`define ACIF_STAT_DIAG 2
`define ACIF_STAT_TALLY_LSB 8
// Interrupt status fields
`define ACIF_IRQ_LEVEL 0
`define ACIF_IRQ_DIAG 1
`define ACIF_IRQ_LOST 2
// Settle codes and default values
`define ACIF_CODE_1MS 5'h0D
`define ACIF_CODE_2MS 5'h0E
`define ACIF_CODE_5MS 5'h0F
`define ACIF_CODE_10MS 5'h10
`define ACIF_CODE_20MS 5'h11
`define ACIF_RISE_RST 5'h0D
`define ACIF_FALL_RST 5'h11
// Settle times in microseconds and clock rate in MHz
`define ACIF_CLK_MHZ 100
`define ACIF_T1MS_US 1000
`define ACIF_T2MS_US 2000
`define ACIF_T5MS_US 5000
`define ACIF_T10MS_US 10000
`define ACIF_T20MS_US 20000
`define ACIF_CYC(us) ((us) * `ACIF_CLK_MHZ)
`endif

// ===== common/acif_pkg.sv
/*
 Types shared by the AC input filter block.
 Assumes nothing beyond the map header for values.
*/
package acif_pkg;
   // APB request from master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } acif_apb_req_t;
   // APB answer to master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } acif_apb_rsp_t;
   // Per-point filter phase
   typedef enum logic [0:0] {
      ACIF_STABLE = 1'b0,
      ACIF_SETTLE = 1'b1
   } acif_phase_t;
endpackage

// ===== design/acif_top.sv
/*
 Sixteen-point AC input filter with quality flags, diag tally and APB registers.
 Assumes raw inputs, fault causes and link state are synchronous to i_clk_sys.
*/
// What this block does
// - On only after settled on for rise time
// - Off only after settled off for fall time
// - Link lost flag is inverse of link
// - Diag flag while any diag or prognostic
// - Tally steps once per cycle with any diag set or clear
// - Tally resets zero, wraps 255 to 1
// - Level bit one when filtered on
// - Bad flag follows bad cause, self-clears
// - Uncertain flag follows cause, self-clears
`include "acif_map.svh"
module acif_top (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire acif_pkg::acif_apb_req_t i_apb,
   output acif_pkg::acif_apb_rsp_t o_apb,
   input wire logic [15:0] i_raw_in,
   input wire logic [15:0] i_bad_cause,
   input wire logic [15:0] i_unc_cause,
   input wire logic i_prog_hit,
   output logic [15:0] o_level,
   output logic [15:0] o_bad,
   output logic [15:0] o_unc,
   output logic o_idle_run_state,
   output logic o_link_lost_flag,
   output logic o_any_diag_flag,
   output logic [7:0] o_diag_event_tally,
   output logic o_irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Settle time lookup
   function automatic logic [20:0] settle_cycles(input logic [4:0] code);
      unique case (code)
         `ACIF_CODE_1MS: settle_cycles = 21'(`ACIF_CYC(`ACIF_T1MS_US));
         `ACIF_CODE_2MS: settle_cycles = 21'(`ACIF_CYC(`ACIF_T2MS_US));
         `ACIF_CODE_5MS: settle_cycles = 21'(`ACIF_CYC(`ACIF_T5MS_US));
         `ACIF_CODE_10MS: settle_cycles = 21'(`ACIF_CYC(`ACIF_T10MS_US));
         `ACIF_CODE_20MS: settle_cycles = 21'(`ACIF_CYC(`ACIF_T20MS_US));
         // Out-of-set codes take shortest time; choice is software's
         default: settle_cycles = 21'(`ACIF_CYC(`ACIF_T1MS_US));
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [2:0] ctrl_ff, nxt_ctrl; // Run, link, prognostic enable
   logic [79:0] rise_settle_code_ff, nxt_rise_settle_code; // Five bits per point
   logic [79:0] fall_settle_code_ff, nxt_fall_settle_code; // Five bits per point
   logic [2:0] irq_sts_ff, nxt_irq_sts; // Sticky events
   logic [2:0] irq_msk_ff, nxt_irq_msk; // Interrupt mask
   logic [15:0] level_ff, nxt_level; // Filtered levels
   logic [15:0] bad_ff, nxt_bad; // Bad-data flags
   logic [15:0] unc_ff, nxt_unc; // Uncertain flags
   logic [7:0] tally_ff, nxt_tally; // Diag event tally
   logic diag_ff, nxt_diag; // Module diag flag
   logic lost_ff, nxt_lost; // Link lost flag
   logic progd_ff; // Registered prognostic condition
   acif_pkg::acif_phase_t phase_ff [16]; // Per-point phase
   acif_pkg::acif_phase_t nxt_phase [16];
   logic [20:0] cnt_ff [16]; // Per-point settle count
   logic [20:0] nxt_cnt [16];
   logic [31:0] rdata_ff, nxt_rdata; // Read data register
   logic wr_en, rd_en, hit; // Bus decode
   logic [32:0] diag_chg; // Distinct conditions that changed

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait states, unmapped reads zero with pslverr
   assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;
   assign rd_en = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
   always_comb begin
      unique case (i_apb.paddr)
         `ACIF_OFF_CTRL, `ACIF_OFF_STAT, `ACIF_OFF_LEVEL, `ACIF_OFF_QUAL, `ACIF_OFF_RISE,
         `ACIF_OFF_RISE + 12'h004, `ACIF_OFF_FALL, `ACIF_OFF_FALL + 12'h004, `ACIF_OFF_IRQ_STS,
         `ACIF_OFF_IRQ_MSK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign o_apb.pready = 1'b1;
   assign o_apb.pslverr = i_apb.psel & i_apb.penable & ~hit;
   assign o_apb.prdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes in access phase and read-data capture in setup phase
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_rise_settle_code = rise_settle_code_ff;
      nxt_fall_settle_code = fall_settle_code_ff;
      nxt_irq_msk = irq_msk_ff;
      nxt_rdata = rdata_ff;
      if (wr_en) begin
         unique case (i_apb.paddr)
            `ACIF_OFF_CTRL: nxt_ctrl = i_apb.pwdata[2:0];
            `ACIF_OFF_RISE: nxt_rise_settle_code[39:0] = pack8(i_apb.pwdata);
            `ACIF_OFF_RISE + 12'h004: nxt_rise_settle_code[79:40] = pack8(i_apb.pwdata);
            `ACIF_OFF_FALL: nxt_fall_settle_code[39:0] = pack8(i_apb.pwdata);
            `ACIF_OFF_FALL + 12'h004: nxt_fall_settle_code[79:40] = pack8(i_apb.pwdata);
            `ACIF_OFF_IRQ_MSK: nxt_irq_msk = i_apb.pwdata[2:0];
            default: ;
         endcase
      end
      if (rd_en) begin
         unique case (i_apb.paddr)
            `ACIF_OFF_CTRL: nxt_rdata = {29'h0, ctrl_ff};
            `ACIF_OFF_STAT: nxt_rdata = {16'h0, tally_ff, 5'h0, diag_ff, lost_ff, ctrl_ff[`ACIF_CTRL_RUN]};
            `ACIF_OFF_LEVEL: nxt_rdata = {16'h0, level_ff};
            `ACIF_OFF_QUAL: nxt_rdata = {unc_ff, bad_ff};
            `ACIF_OFF_RISE: nxt_rdata = unpack8(rise_settle_code_ff[39:0]);
            `ACIF_OFF_RISE + 12'h004: nxt_rdata = unpack8(rise_settle_code_ff[79:40]);
            `ACIF_OFF_FALL: nxt_rdata = unpack8(fall_settle_code_ff[39:0]);
            `ACIF_OFF_FALL + 12'h004: nxt_rdata = unpack8(fall_settle_code_ff[79:40]);
            `ACIF_OFF_IRQ_STS: nxt_rdata = {29'h0, irq_sts_ff};
            `ACIF_OFF_IRQ_MSK: nxt_rdata = {29'h0, irq_msk_ff};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Eight five-bit codes come from the eight nibbles; a zero nibble means code 5'h10
   function automatic logic [39:0] pack8(input logic [31:0] w);
      for (int i = 0; i < 8; i++) pack8[i*5 +: 5] = w[i*4 +: 4] == 4'h0 ? 5'h10 : {1'b0, w[i*4 +: 4]};
   endfunction
   function automatic logic [31:0] unpack8(input logic [39:0] c);
      for (int i = 0; i < 8; i++) unpack8[i*4 +: 4] = c[i*5 +: 4];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-point settle filter
   always_comb begin
      for (int p = 0; p < 16; p++) begin
         nxt_phase[p] = phase_ff[p];
         nxt_cnt[p] = cnt_ff[p];
         nxt_level[p] = level_ff[p];
         if (i_raw_in[p] == level_ff[p]) begin
            // Raw matches output: drop any pending change
            nxt_phase[p] = acif_pkg::ACIF_STABLE;
            nxt_cnt[p] = 21'h0;
         end else if (cnt_ff[p] + 21'h1 >= (level_ff[p] ? settle_cycles(fall_settle_code_ff[p*5 +: 5])
                                                   : settle_cycles(rise_settle_code_ff[p*5 +: 5]))) begin
            nxt_level[p] = i_raw_in[p];
            nxt_phase[p] = acif_pkg::ACIF_STABLE;
            nxt_cnt[p] = 21'h0;
         end else begin
            nxt_phase[p] = acif_pkg::ACIF_SETTLE;
            nxt_cnt[p] = cnt_ff[p] + 21'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Quality flags, module flags, tally and interrupts
   always_comb begin
      nxt_bad = i_bad_cause;
      nxt_unc = i_unc_cause;
      nxt_lost = ~ctrl_ff[`ACIF_CTRL_LINK];
      nxt_diag = (|i_bad_cause) | (|i_unc_cause) | (i_prog_hit & ctrl_ff[`ACIF_CTRL_PROG]);
      diag_chg = {i_bad_cause ^ bad_ff, i_unc_cause ^ unc_ff, (i_prog_hit & ctrl_ff[`ACIF_CTRL_PROG]) ^ progd_ff};
      nxt_tally = tally_ff;
      if (|diag_chg) begin
         // One step per cycle in which any distinct condition has an edge
         nxt_tally = tally_ff == 8'hFF ? 8'h01 : tally_ff + 8'h01;
      end
      nxt_irq_sts = irq_sts_ff;
      if (wr_en && i_apb.paddr == `ACIF_OFF_IRQ_STS) nxt_irq_sts = irq_sts_ff & ~i_apb.pwdata[2:0];
      // Set beats clear
      nxt_irq_sts[`ACIF_IRQ_LEVEL] = nxt_irq_sts[`ACIF_IRQ_LEVEL] | (|(nxt_level ^ level_ff));
      nxt_irq_sts[`ACIF_IRQ_DIAG] = nxt_irq_sts[`ACIF_IRQ_DIAG] | (|diag_chg);
      nxt_irq_sts[`ACIF_IRQ_LOST] = nxt_irq_sts[`ACIF_IRQ_LOST] | (nxt_lost & ~lost_ff);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_ff <= 3'h0;
         rise_settle_code_ff <= {16{`ACIF_RISE_RST}};
         fall_settle_code_ff <= {16{`ACIF_FALL_RST}};
         irq_sts_ff <= 3'h0;
         irq_msk_ff <= 3'h0;
         level_ff <= 16'h0000;
         bad_ff <= 16'h0000;
         unc_ff <= 16'h0000;
         tally_ff <= 8'h00;
         diag_ff <= 1'b0;
         lost_ff <= 1'b1;
         progd_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         for (int p = 0; p < 16; p++) begin
            phase_ff[p] <= acif_pkg::ACIF_STABLE;
            cnt_ff[p] <= 21'h0;
         end
      end else begin
         ctrl_ff <= nxt_ctrl;
         rise_settle_code_ff <= nxt_rise_settle_code;
         fall_settle_code_ff <= nxt_fall_settle_code;
         irq_sts_ff <= nxt_irq_sts;
         irq_msk_ff <= nxt_irq_msk;
         level_ff <= nxt_level;
         bad_ff <= nxt_bad;
         unc_ff <= nxt_unc;
         tally_ff <= nxt_tally;
         diag_ff <= nxt_diag;
         lost_ff <= nxt_lost;
         progd_ff <= i_prog_hit & ctrl_ff[`ACIF_CTRL_PROG];
         rdata_ff <= nxt_rdata;
         for (int p = 0; p < 16; p++) begin
            phase_ff[p] <= nxt_phase[p];
            cnt_ff[p] <= nxt_cnt[p];
         end
      end
   end

   // Outputs from flip-flops
   assign o_level = level_ff;
   assign o_bad = bad_ff;
   assign o_unc = unc_ff;
   assign o_idle_run_state = ctrl_ff[`ACIF_CTRL_RUN];
   assign o_link_lost_flag = lost_ff;
   assign o_any_diag_flag = diag_ff;
   assign o_diag_event_tally = tally_ff;
   assign o_irq = |(irq_sts_ff & irq_msk_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_lost_follows_link:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      ##1 o_link_lost_flag == ~$past(ctrl_ff[`ACIF_CTRL_LINK]))
      else $error("link lost flag wrong");
   a_tally_wraps:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      tally_ff == 8'hFF && (|diag_chg) |=> tally_ff == 8'h01)
      else $error("tally did not wrap to one");
   a_tally_no_zero:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      tally_ff != 8'h00 |=> tally_ff != 8'h00)
      else $error("tally returned to zero");
   a_tally_step:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (|diag_chg) && tally_ff != 8'hFF |=> tally_ff == $past(tally_ff) + 8'h01)
      else $error("tally did not step");
   a_bad_follows:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      ##1 o_bad == $past(i_bad_cause))
      else $error("bad flags wrong");
   a_unc_follows:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      ##1 o_unc == $past(i_unc_cause))
      else $error("uncertain flags wrong");
   a_diag_flag:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      (|i_bad_cause) |=> o_any_diag_flag)
      else $error("diag flag missing");
   a_rise_hold:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      !level_ff[0] && i_raw_in[0] && cnt_ff[0] == 21'h0 |=> !level_ff[0])
      else $error("point rose too early");
   a_fall_hold:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      level_ff[0] && !i_raw_in[0] && cnt_ff[0] == 21'h0 |=> level_ff[0])
      else $error("point fell too early");
   a_cnt_restart:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      i_raw_in[0] == level_ff[0] |=> cnt_ff[0] == 21'h0)
      else $error("settle count not restarted");
   a_cnt_advance:
   assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
      i_raw_in[0] != level_ff[0] && cnt_ff[0] == 21'h0 |=> cnt_ff[0] == 21'h1)
      else $error("settle count did not advance");
endmodule

// ===== sim/acif_ctrl_model.sv
/*
 Owning controller model: APB master that reaches the filter block registers.
 Assumes a slave that may answer at once or after wait states on pready.
*/
`include "acif_map.svh"
module acif_ctrl_model (
   input wire logic i_clk_sys,
   input wire acif_pkg::acif_apb_rsp_t i_rsp,
   output acif_pkg::acif_apb_req_t o_req
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////
   // Bus idle at start
   initial begin
      o_req = '0;
   end
   // One APB transfer, setup then access until pready
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge i_clk_sys);
      o_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_clk_sys);
      o_req.penable <= 1'b1;
      // Hold request until the answer is sampled
      do @(posedge i_clk_sys); while (i_rsp.pready !== 1'b1);
      rd = i_rsp.prdata;
      err = i_rsp.pslverr;
      o_req.psel <= 1'b0;
      o_req.penable <= 1'b0;
   endtask
   // Settle codes for a 240 V field: rise 15 on every point, fall 1 (out of set, 1 ms) on points 0 to 7
   task automatic cfg_240(output logic [31:0] rd, output logic err);
      xfer(1'b1, `ACIF_OFF_RISE, 32'hFFFF_FFFF, rd, err);
      xfer(1'b1, `ACIF_OFF_RISE + 12'h004, 32'hFFFF_FFFF, rd, err);
      xfer(1'b1, `ACIF_OFF_FALL, 32'h1111_1111, rd, err);
   endtask
endmodule

// ===== sim/ac_input_filter_status_bench.sv
/*
 Self-checking bench for the AC input filter block.
 Assumes the controller model as APB master and a 100 MHz clock.
*/
`include "acif_map.svh"
module ac_input_filter_status_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 1'b0; // System clock
   logic i_arst_n = 1'b0; // Reset, active low
   logic [15:0] raw = 16'h0000; // Raw points
   logic [15:0] bad = 16'h0000; // Bad causes
   logic [15:0] unc = 16'h0000; // Uncertain causes
   logic prog = 1'b0; // Prognostic hit
   acif_pkg::acif_apb_req_t req; // Bus request
   acif_pkg::acif_apb_rsp_t rsp; // Bus answer
   logic [15:0] lvl, obad, ounc; // Point outputs
   logic run_st, lost, diag, irq; // Module flags
   logic [7:0] tally, exp_tally; // Tally and its expectation
   logic [31:0] rd; // Read data
   logic err; // Slave error
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////
   // Clock
   always #5 i_clk_sys = ~i_clk_sys;
   acif_top i_acif_top (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_apb(req), .o_apb(rsp),
      .i_raw_in(raw), .i_bad_cause(bad), .i_unc_cause(unc), .i_prog_hit(prog), .o_level(lvl),
      .o_bad(obad), .o_unc(ounc), .o_idle_run_state(run_st), .o_link_lost_flag(lost),
      .o_any_diag_flag(diag), .o_diag_event_tally(tally), .o_irq(irq));
   acif_ctrl_model i_acif_ctrl_model (.i_clk_sys(i_clk_sys), .i_rsp(rsp), .o_req(req));
   ////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic complete_run;
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   // Hang guard
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         complete_run();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_acif_ctrl_model.xfer(1'b1, a, d, rd, err);
   endtask
   task automatic rdr(input logic [11:0] a);
      i_acif_ctrl_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
   endtask
   // Let n edges pass, then sample at the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
   endtask
   // Expected tally step, skipping zero
   task automatic bump;
      exp_tally = (exp_tally == 8'hFF) ? 8'h01 : exp_tally + 8'h01;
   endtask
   ////////////////////////////////////////////////////////////////
   // Reset values and default codes
   task automatic t_reset;
      @(negedge i_clk_sys);
      check(lost, 1'b1);
      check(tally, 8'h00);
      check(lvl, 16'h0000);
      check(irq, 1'b0);
      rdr(`ACIF_OFF_RISE);
      check(rd, 32'hDDDD_DDDD);
      rdr(`ACIF_OFF_FALL);
      check(rd, 32'h1111_1111);
   endtask
   // Link running and stopped
   task automatic t_link;
      wr(`ACIF_OFF_CTRL, 32'h0000_0003);
      settle(2);
      check(lost, 1'b0);
      check(run_st, 1'b1);
      rdr(`ACIF_OFF_STAT);
      check(rd[`ACIF_STAT_LOST], 1'b0);
      wr(`ACIF_OFF_CTRL, 32'h0000_0001);
      settle(2);
      check(lost, 1'b1);
   endtask
   // Bad and uncertain flags follow their causes
   task automatic t_quality;
      @(posedge i_clk_sys) bad <= 16'h0008;
      settle(3);
      bump();
      check(obad, 16'h0008);
      check(diag, 1'b1);
      check(tally, exp_tally);
      @(posedge i_clk_sys) bad <= 16'h0000;
      settle(3);
      bump();
      check(obad, 16'h0000);
      check(diag, 1'b0);
      check(tally, exp_tally);
      @(posedge i_clk_sys) unc <= 16'h0200;
      settle(3);
      bump();
      check(ounc, 16'h0200);
      @(posedge i_clk_sys) unc <= 16'h0000;
      settle(3);
      bump();
      check(ounc, 16'h0000);
      check(tally, exp_tally);
   endtask
   // Prognostic threshold drives the diag flag
   task automatic t_prog;
      wr(`ACIF_OFF_CTRL, 32'h0000_0007);
      @(posedge i_clk_sys) prog <= 1'b1;
      settle(3);
      bump();
      check(diag, 1'b1);
      @(posedge i_clk_sys) prog <= 1'b0;
      settle(3);
      bump();
      check(diag, 1'b0);
      check(tally, exp_tally);
   endtask
   // Tally wraps past 255 without zero
   task automatic t_wrap;
      repeat (256) begin
         @(posedge i_clk_sys) unc[0] <= ~unc[0];
         bump();
         settle(1);
      end
      settle(2);
      check(tally, exp_tally);
   endtask
   // Short pulses never reach the filtered level
   task automatic t_glitch;
      i_acif_ctrl_model.cfg_240(rd, err);
      rdr(`ACIF_OFF_RISE);
      check(rd, 32'hFFFF_FFFF);
      @(posedge i_clk_sys) raw <= 16'hFFFF;
      settle(900);
      check(lvl, 16'h0000);
      @(posedge i_clk_sys) raw <= 16'h0000;
      settle(3);
      @(posedge i_clk_sys) raw <= 16'hFFFF;
      settle(900);
      check(lvl, 16'h0000);
      @(posedge i_clk_sys) raw <= 16'h0000;
   endtask
   // Interrupt raise, clear, mask, and an unmapped access
   task automatic t_irq;
      wr(`ACIF_OFF_IRQ_STS, 32'h0000_0007);
      wr(`ACIF_OFF_IRQ_MSK, 32'h0000_0002);
      @(posedge i_clk_sys) bad <= 16'h0001;
      settle(3);
      bump();
      check(irq, 1'b1);
      wr(`ACIF_OFF_IRQ_STS, 32'h0000_0002);
      settle(1);
      check(irq, 1'b0);
      wr(`ACIF_OFF_IRQ_MSK, 32'h0000_0000);
      @(posedge i_clk_sys) bad <= 16'h0000;
      settle(3);
      bump();
      check(irq, 1'b0);
      check(tally, exp_tally);
      rdr(12'h03C);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      exp_tally = 8'h00;
      repeat (16) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      t_reset();
      t_link();
      t_quality();
      t_prog();
      t_wrap();
      t_glitch();
      t_irq();
      complete_run();
   end
endmodule
